/* File: rtl/dtio_cfg.svh */
// dtio_cfg.svh: offsets-free constants for the drive terminal io logic.
// assumes inclusion by bare name from the delay and top design files.
`ifndef DTIO_CFG_SVH
`define DTIO_CFG_SVH

`define DTIO_CLK_HZ 40000000
`define DTIO_TICK_MS 100
`define DTIO_TICK_CYC ((`DTIO_CLK_HZ / 1000) * `DTIO_TICK_MS)
`define DTIO_DELAY_MAX_TENTHS 36000
`define DTIO_PULSE_MS 250
`define DTIO_PULSE_CYC ((`DTIO_CLK_HZ / 1000) * `DTIO_PULSE_MS)
`define DTIO_OVL_LEAD_S 10
`define DTIO_OVL_LEAD_TENTHS (`DTIO_OVL_LEAD_S * 10)
`define DTIO_CURVE_SEL_RST 12'h321
`define DTIO_BELOW_MIN_RST 12'h000
`define DTIO_VALID_MODE_RST 20'h00000
`define DTIO_OC_FUNC_RST 8'h00
`define DTIO_RELAY_FUNC_RST 8'h02
`define DTIO_PCT_ZERO 16'h0000

`endif

/* File: rtl/dtio_pkg.sv */
// dtio_pkg: types shared by the terminal io logic.
// assumes dtio_cfg.svh is on the include path.
package dtio_pkg;
   typedef enum logic [1:0] {
      dtio_st_idle,
      dtio_st_count,
      dtio_st_done
   } dtio_dly_e;
   typedef struct packed {
      logic running;
      logic fault_stop;
      logic freq_zero;
      logic motor_ovl_warn;
      logic [15:0] drive_ovl_left;
      logic count_set_hit;
      logic count_des_hit;
      logic length_hit;
      logic seq_cycle_done;
      logic run_time_hit;
      logic set_freq_beyond;
      logic out_freq_at_limit;
      logic speed_mode;
      logic torque_stall;
      logic ready_to_run;
      logic freq_detect_one;
      logic freq_reached;
   } dtio_status_s;
   typedef struct packed {
      logic [15:0] raw;
      logic [15:0] min_point;
      logic [15:0] min_setting;
   } dtio_ain_s;
endpackage

/* File: rtl/dtio_delay.sv */
// dtio_delay: one filtered digital input with programmable change delay.
// assumes a 100 ms tick enable from the parent and a synchronised input.
`timescale 1ns/1ps
`default_nettype none
`include "dtio_cfg.svh"
module dtio_delay (
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic level_in,
   input wire logic [15:0] delay_tenths,
   output logic level_out
);
   typedef struct packed {
      dtio_pkg::dtio_dly_e st;
      logic [15:0] cnt;
      logic out;
   } dtio_dly_state_s;
   dtio_dly_state_s s, next_s;
   logic [15:0] lim;

   always_comb begin
      lim = (delay_tenths > 16'(`DTIO_DELAY_MAX_TENTHS)) ?
            16'(`DTIO_DELAY_MAX_TENTHS) : delay_tenths;
      next_s = s;
      case (s.st)
         dtio_pkg::dtio_st_idle: begin
            if (level_in != s.out) begin
               next_s.cnt = 16'h0000;
               if (lim == 16'h0000) begin
                  next_s.out = level_in;
               end else begin
                  next_s.st = dtio_pkg::dtio_st_count;
               end
            end
         end
         dtio_pkg::dtio_st_count: begin
            // a change that reverts before the delay expires is dropped
            if (level_in == s.out) begin
               next_s.st = dtio_pkg::dtio_st_idle;
            end else if (tick) begin
               next_s.cnt = s.cnt + 16'h0001;
               if (s.cnt + 16'h0001 >= lim) begin
                  next_s.st = dtio_pkg::dtio_st_done;
               end
            end
         end
         dtio_pkg::dtio_st_done: begin
            next_s.out = level_in;
            next_s.st = dtio_pkg::dtio_st_idle;
         end
         default: begin
            next_s.st = dtio_pkg::dtio_st_idle;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '{dtio_pkg::dtio_st_idle, 16'h0000, 1'b0};
      end else begin
         s <= next_s;
      end
   end
   assign level_out = s.out;
endmodule
`default_nettype wire

/* File: rtl/dtio_top.sv */
// dtio_top: drive terminal logic; analog curve select, input delay and
// polarity, and two function-coded digital outputs.
// assumes status flags come from logic on clk; terminals are asynchronous.
// Notes on behaviour
// [R1] units digit picks first analog curve, tens digit picks second; any of five
// [R2] curves one and two are two-point; four and five are four-point
// [R3] curve three is two-point with its own minimum and maximum points
// [R4] below-minimum digits: units first input, tens second, hundreds reserved, default 000
// [R5] digit zero below minimum yields the curve's minimum-input setting
// [R6] digit one below minimum yields zero percent
// [R7] inputs one to three delay changes up to 3600.0 s; others none
// [R8] valid-mode digits set polarity of inputs one to five; 1 is active low
// [R9] active high input is asserted while tied to common return
// [R10] two outputs each have a function code; defaults 0 and 2
// [R11] code 1 asserts while running, zero frequency included
// [R12] code 2 asserts when stopped by fault
// [R13] code 5 asserts running at zero frequency, off when stopped
// [R14] code 6 asserts above motor overload pre-warning threshold
// [R15] code 7 asserts 10 s before drive overload protection acts
// [R16] codes 8 and 9 assert on set and designated count reached
// [R17] code 10 asserts when actual length exceeds threshold
// [R18] code 11 gives one 250 ms pulse per sequencer cycle
// [R19] code 12 asserts when accumulated run time exceeds threshold
// [R20] code 13 asserts when set frequency beyond limit and output at limit
// [R21] code 14 asserts on torque stall in speed control mode
// [R22] code 15 asserts when ready to run without fault
// [R23] code 16 asserts while first analog input exceeds second
// [R24] codes 3, 4 follow external detect flags; other codes stay inactive
// [R25] input delay timing comes from a reset-cleared tick counter on clk; the pulse has its own counter
`timescale 1ns/1ps
`default_nettype none
`include "dtio_cfg.svh"
module dtio_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [11:0] curve_sel,
   input wire logic [11:0] below_min_sel,
   input wire logic [19:0] valid_mode,
   input wire logic [15:0] delay_one_tenths,
   input wire logic [15:0] delay_two_tenths,
   input wire logic [15:0] delay_three_tenths,
   input wire logic [7:0] oc_func,
   input wire logic [7:0] relay_func,
   input wire dtio_pkg::dtio_ain_s analog_in_first,
   input wire dtio_pkg::dtio_ain_s analog_in_second,
   input wire logic [4:0] digital_in_n,
   input wire dtio_pkg::dtio_status_s status,
   output logic [2:0] curve_first,
   output logic [2:0] curve_second,
   output logic curve_first_four_point,
   output logic curve_second_four_point,
   output logic [15:0] setting_first,
   output logic [15:0] setting_second,
   output logic [4:0] digital_in_active,
   output logic oc_out,
   output logic relay_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [4:0] sync3;
      logic [4:0] level;
      logic [21:0] tick_cnt;
      logic [23:0] pulse_cnt;
      logic seq_prev;
      logic [2:0] curve_a;
      logic [2:0] curve_b;
      logic four_a;
      logic four_b;
      logic [15:0] set_a;
      logic [15:0] set_b;
      logic [4:0] active;
      logic oc;
      logic relay;
   } dtio_state_s;
   dtio_state_s s, next_s;
   logic tick;
   logic [2:0] delayed;
   logic pulse_on;

   // digit decode is used for both analog inputs
   function automatic logic [2:0] curve_of(input logic [3:0] digit);
      curve_of = (digit >= 4'h1 && digit <= 4'h5) ? digit[2:0] : 3'h1;
   endfunction

   function automatic logic [15:0] scale(input dtio_pkg::dtio_ain_s a,
                                         input logic [3:0] mode);
      if (a.raw < a.min_point) begin
         scale = (mode == 4'h1) ? `DTIO_PCT_ZERO : a.min_setting;
      end else begin
         scale = a.raw;
      end
   endfunction

   function automatic logic out_of(input logic [7:0] code,
                                   input dtio_pkg::dtio_status_s st,
                                   input logic pulse,
                                   input logic [15:0] a,
                                   input logic [15:0] b);
      case (code)
         8'h01: out_of = st.running; // [R11]
         8'h02: out_of = st.fault_stop; // [R12]
         8'h03: out_of = st.freq_detect_one; // [R24]
         8'h04: out_of = st.freq_reached; // [R24]
         8'h05: out_of = st.running & st.freq_zero; // [R13]
         8'h06: out_of = st.motor_ovl_warn; // [R14]
         8'h07: out_of = st.drive_ovl_left <= 16'(`DTIO_OVL_LEAD_TENTHS); // [R15]
         8'h08: out_of = st.count_set_hit; // [R16]
         8'h09: out_of = st.count_des_hit; // [R16]
         8'h0A: out_of = st.length_hit; // [R17]
         8'h0B: out_of = pulse; // [R18]
         8'h0C: out_of = st.run_time_hit; // [R19]
         8'h0D: out_of = st.set_freq_beyond & st.out_freq_at_limit; // [R20]
         8'h0E: out_of = st.speed_mode & st.torque_stall; // [R21]
         8'h0F: out_of = st.ready_to_run & ~st.fault_stop; // [R22]
         8'h10: out_of = a > b; // [R23]
         default: out_of = 1'b0; // [R10] [R24]
      endcase
   endfunction

   // ----------------------------------------------------------------
   // input delays
   // ----------------------------------------------------------------
   logic [15:0] dly_set [3];
   assign dly_set[0] = delay_one_tenths;
   assign dly_set[1] = delay_two_tenths;
   assign dly_set[2] = delay_three_tenths;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_dly
         dtio_delay u_dly (
            .clk(clk),
            .reset(reset),
            .tick(tick),
            .level_in(s.level[gi]),
            .delay_tenths(dly_set[gi]),
            .level_out(delayed[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.sync1 = digital_in_n;
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;
      for (int i = 0; i < 5; i++) begin
         if (s.sync2[i] == s.sync3[i]) begin
            // low pin means terminal closed to common return
            next_s.level[i] = ~s.sync3[i]; // [R9]
         end
      end
      // 100 ms tick drives every delay count
      if (s.tick_cnt == 22'(`DTIO_TICK_CYC - 1)) begin // [R25]
         next_s.tick_cnt = 22'h000000;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 22'h000001;
      end
      next_s.seq_prev = status.seq_cycle_done;
      if (status.seq_cycle_done && !s.seq_prev) begin
         next_s.pulse_cnt = 24'(`DTIO_PULSE_CYC); // [R18]
      end else if (s.pulse_cnt != 24'h000000) begin
         next_s.pulse_cnt = s.pulse_cnt - 24'h000001;
      end
      next_s.curve_a = curve_of(curve_sel[3:0]); // [R1]
      next_s.curve_b = curve_of(curve_sel[7:4]); // [R1]
      next_s.four_a = next_s.curve_a >= 3'h4; // [R2] [R3]
      next_s.four_b = next_s.curve_b >= 3'h4; // [R2] [R3]
      next_s.set_a = scale(analog_in_first, below_min_sel[3:0]); // [R4] [R5] [R6]
      next_s.set_b = scale(analog_in_second, below_min_sel[7:4]); // [R4] [R5] [R6]
      for (int i = 0; i < 3; i++) begin
         next_s.active[i] = delayed[i] ^ valid_mode[4 * i]; // [R7] [R8]
      end
      for (int i = 3; i < 5; i++) begin
         next_s.active[i] = s.level[i] ^ valid_mode[4 * i]; // [R8]
      end
      next_s.oc = out_of(oc_func, status, pulse_on, s.set_a, s.set_b); // [R10] [R24]
      next_s.relay = out_of(relay_func, status, pulse_on, s.set_a, s.set_b); // [R10]
   end
   assign tick = (s.tick_cnt == 22'(`DTIO_TICK_CYC - 1));
   assign pulse_on = (s.pulse_cnt != 24'h000000);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
         s.sync1 <= 5'h1F;
         s.sync2 <= 5'h1F;
         s.sync3 <= 5'h1F;
         s.curve_a <= 3'h1;
         s.curve_b <= 3'h2;
      end else begin
         s <= next_s;
      end
   end

   assign curve_first = s.curve_a;
   assign curve_second = s.curve_b;
   assign curve_first_four_point = s.four_a;
   assign curve_second_four_point = s.four_b;
   assign setting_first = s.set_a;
   assign setting_second = s.set_b;
   assign digital_in_active = s.active;
   assign oc_out = s.oc;
   assign relay_out = s.relay;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pulse_width: assert property (@(posedge clk) disable iff (reset) // [R18]
      $rose(status.seq_cycle_done) |=> pulse_on [*8])
      else $error("sequencer pulse too short");
   a_zero_pct: assert property (@(posedge clk) disable iff (reset) // [R6]
      (analog_in_first.raw < analog_in_first.min_point && below_min_sel[3:0] == 4'h1)
      |=> setting_first == 16'h0000)
      else $error("below minimum not zero");
   a_min_setting: assert property (@(posedge clk) disable iff (reset) // [R5]
      (analog_in_second.raw < analog_in_second.min_point && below_min_sel[7:4] == 4'h0)
      |=> setting_second == $past(analog_in_second.min_setting))
      else $error("below minimum not min setting");
   a_code_zero: assert property (@(posedge clk) disable iff (reset) // [R10]
      oc_func == 8'h00 |=> !oc_out)
      else $error("code zero drives output");
   a_run_out: assert property (@(posedge clk) disable iff (reset) // [R11]
      relay_func == 8'h01 |=> relay_out == $past(status.running))
      else $error("running output wrong");
   a_zero_speed: assert property (@(posedge clk) disable iff (reset) // [R13]
      (oc_func == 8'h05 && !status.running) |=> !oc_out)
      else $error("zero speed on at stop");
   a_ai_compare: assert property (@(posedge clk) disable iff (reset) // [R23]
      (relay_func == 8'h10 && $stable(setting_first) && $stable(setting_second))
      |=> relay_out == $past(setting_first > setting_second))
      else $error("analog compare wrong");
   a_curve_four: assert property (@(posedge clk) disable iff (reset) // [R2]
      curve_first_four_point == (curve_first >= 3'h4))
      else $error("curve point count wrong");
   a_tick_span: assert property (@(posedge clk) disable iff (reset) // [R25]
      tick |=> !tick [*8])
      else $error("tick too frequent");

   // curve point count follows the selected curve on both inputs
   a_curve_second: assert property (@(posedge clk) disable iff (reset) // [R2]
      curve_second_four_point == (curve_second >= 3'h4))
      else $error("second curve point count wrong");

   // function codes: each output follows its flags one registered cycle later; the code 11 pulse starts two cycles after its event
   a_run_oc: assert property (@(posedge clk) disable iff (reset) // [R11]
      oc_func == 8'h01 |=> oc_out == $past(status.running))
      else $error("running open collector wrong");
   a_fault_out: assert property (@(posedge clk) disable iff (reset) // [R12]
      relay_func == 8'h02 |=> relay_out == $past(status.fault_stop))
      else $error("fault output wrong");
   a_detect_one: assert property (@(posedge clk) disable iff (reset) // [R24]
      relay_func == 8'h03 |=> relay_out == $past(status.freq_detect_one))
      else $error("level detect output wrong");
   a_freq_reached: assert property (@(posedge clk) disable iff (reset) // [R24]
      oc_func == 8'h04 |=> oc_out == $past(status.freq_reached))
      else $error("frequency reached output wrong");
   a_zero_run: assert property (@(posedge clk) disable iff (reset) // [R13]
      relay_func == 8'h05 |=> relay_out == $past(status.running && status.freq_zero))
      else $error("zero speed relay wrong");
   a_ovl_warn: assert property (@(posedge clk) disable iff (reset) // [R14]
      oc_func == 8'h06 |=> oc_out == $past(status.motor_ovl_warn))
      else $error("motor overload warning wrong");
   a_ovl_lead: assert property (@(posedge clk) disable iff (reset) // [R15]
      (relay_func == 8'h07 && status.drive_ovl_left > 16'(`DTIO_OVL_LEAD_TENTHS)) |=> !relay_out)
      else $error("overload lead too early");
   a_count_set: assert property (@(posedge clk) disable iff (reset) // [R16]
      relay_func == 8'h08 |=> relay_out == $past(status.count_set_hit))
      else $error("set count output wrong");
   a_count_des: assert property (@(posedge clk) disable iff (reset) // [R16]
      oc_func == 8'h09 |=> oc_out == $past(status.count_des_hit))
      else $error("designated count output wrong");
   a_length_out: assert property (@(posedge clk) disable iff (reset) // [R17]
      oc_func == 8'h0A |=> oc_out == $past(status.length_hit))
      else $error("length output wrong");
   a_pulse_idle: assert property (@(posedge clk) disable iff (reset) // [R18]
      (oc_func == 8'h0B && !pulse_on) |=> !oc_out)
      else $error("sequencer pulse without event");
   a_pulse_seen: assert property (@(posedge clk) disable iff (reset) // [R18]
      (oc_func == 8'h0B && $rose(status.seq_cycle_done)) ##1 oc_func == 8'h0B |=> oc_out)
      else $error("sequencer pulse missing");
   a_run_time: assert property (@(posedge clk) disable iff (reset) // [R19]
      relay_func == 8'h0C |=> relay_out == $past(status.run_time_hit))
      else $error("run time output wrong");
   a_freq_limit: assert property (@(posedge clk) disable iff (reset) // [R20]
      oc_func == 8'h0D |=> oc_out == $past(status.set_freq_beyond && status.out_freq_at_limit))
      else $error("frequency limit output wrong");
   a_torque_stall: assert property (@(posedge clk) disable iff (reset) // [R21]
      (relay_func == 8'h0E && !status.speed_mode) |=> !relay_out)
      else $error("stall output outside speed mode");
   a_ready_run: assert property (@(posedge clk) disable iff (reset) // [R22]
      (oc_func == 8'h0F && status.fault_stop) |=> !oc_out)
      else $error("ready output with fault");
   a_unused_code: assert property (@(posedge clk) disable iff (reset) // [R24]
      relay_func > 8'h10 |=> !relay_out)
      else $error("unused code drives relay");
endmodule
`default_nettype wire

/* File: dv/dtio_field.sv */
// dtio_field: field contacts and drive status source for the bench.
// assumes bench commands on clk; presents them one cycle later.
`timescale 1ns/1ps
`default_nettype none
module dtio_field (
   input wire logic clk,
   input wire logic [4:0] closed,
   input wire dtio_pkg::dtio_status_s st_cmd,
   output logic [4:0] digital_in_n,
   output var dtio_pkg::dtio_status_s status
);
   // an open contact floats to the pull-up, a closed one sits at common return
   always_ff @(posedge clk) begin
      digital_in_n <= ~closed;
      status <= st_cmd;
   end
endmodule
`default_nettype wire

/* File: dv/drive_terminal_io_logic_tb.sv */
// drive_terminal_io_logic_tb: directed checks of curve, input and output logic.
// assumes dtio_top and dtio_field; tick-long delays are checked only while still counting, never to expiry.
`timescale 1ns/1ps
`default_nettype none
module drive_terminal_io_logic_tb;
   logic clk;
   logic reset;
   logic [11:0] curve_sel;
   logic [11:0] below_min_sel;
   logic [19:0] valid_mode;
   logic [7:0] oc_func;
   logic [7:0] relay_func;
   dtio_pkg::dtio_ain_s ain1;
   dtio_pkg::dtio_ain_s ain2;
   dtio_pkg::dtio_status_s st_cmd;
   dtio_pkg::dtio_status_s status;
   dtio_pkg::dtio_status_s st0;
   dtio_pkg::dtio_status_s s;
   logic [4:0] closed;
   logic [4:0] pins_n;
   logic [4:0] active;
   logic [2:0] curve1;
   logic [2:0] curve2;
   logic four1;
   logic four2;
   logic oc_out;
   logic relay_out;
   logic [15:0] set1;
   logic [15:0] set2;
   logic [15:0] dly;
   int error_cnt;
   int cmp_count;
   int cyc;

   dtio_field u_field (.clk(clk), .closed(closed), .st_cmd(st_cmd),
      .digital_in_n(pins_n), .status(status));
   dtio_top u_dut (.clk(clk), .reset(reset), .curve_sel(curve_sel),
      .below_min_sel(below_min_sel), .valid_mode(valid_mode),
      .delay_one_tenths(dly), .delay_two_tenths(dly),
      .delay_three_tenths(dly), .oc_func(oc_func), .relay_func(relay_func),
      .analog_in_first(ain1), .analog_in_second(ain2), .digital_in_n(pins_n),
      .status(status), .curve_first(curve1), .curve_second(curve2),
      .curve_first_four_point(four1), .curve_second_four_point(four2),
      .setting_first(set1), .setting_second(set2), .digital_in_active(active),
      .oc_out(oc_out), .relay_out(relay_out));

   // ----------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // a hang past the expected run length ends the run as a failure
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (exp !== got) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // both outputs get the same code so each case checks both selectors
   task automatic code_case(input logic [7:0] code, input dtio_pkg::dtio_status_s st,
                            input logic exp);
      @(posedge clk);
      oc_func <= code;
      relay_func <= code;
      st_cmd <= st;
      settle(4);
      chk("oc_out", 16'(exp), 16'(oc_out));
      chk("relay_out", 16'(exp), 16'(relay_out));
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      st0 = '0;
      st0.drive_ovl_left = 16'hFFFF;
      reset = 1'b1;
      curve_sel = 12'h321;
      below_min_sel = 12'h000;
      valid_mode = 20'h00000;
      oc_func = 8'h00;
      relay_func = 8'h02;
      ain1 = '0;
      ain2 = '0;
      st_cmd = st0;
      closed = 5'h00;
      dly = 16'h0000;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      settle(3);
      chk("curve_first", 16'h0001, 16'(curve1));
      chk("curve_second", 16'h0002, 16'(curve2));
      chk("relay_idle", 16'h0000, 16'(relay_out));
      for (int c = 1; c <= 5; c++) begin
         @(posedge clk);
         curve_sel <= {4'h0, 4'(6 - c), 4'(c)};
         settle(2);
         chk("curve_first", 16'(c), 16'(curve1));
         chk("curve_second", 16'(6 - c), 16'(curve2));
         chk("four_first", 16'(c >= 4), 16'(four1));
         chk("four_second", 16'(c <= 2), 16'(four2));
      end
      // digits outside one to five fall back to curve one
      @(posedge clk);
      curve_sel <= 12'h097;
      settle(2);
      chk("curve_first", 16'h0001, 16'(curve1));
      chk("curve_second", 16'h0001, 16'(curve2));
      @(posedge clk);
      ain1 <= {16'h0010, 16'h0100, 16'h0555};
      ain2 <= {16'h0050, 16'h0100, 16'h0777};
      below_min_sel <= 12'h010;
      settle(2);
      chk("setting_first", 16'h0555, set1);
      chk("setting_second", 16'h0000, set2);
      @(posedge clk);
      below_min_sel <= 12'h101;
      settle(2);
      chk("setting_first", 16'h0000, set1);
      chk("setting_second", 16'h0777, set2);
      @(posedge clk);
      closed <= 5'b01001;
      settle(12);
      chk("active", 16'h0009, 16'(active));
      @(posedge clk);
      valid_mode <= 20'h11000;
      settle(12);
      chk("active", 16'h0011, 16'(active));
      // a one-tick delay outlasts the run, so input one must hold its old state
      @(posedge clk);
      dly <= 16'h0001;
      closed <= 5'b01000;
      settle(12);
      chk("active_held", 16'h0011, 16'(active));
      @(posedge clk);
      closed <= 5'b01001;
      settle(12);
      chk("active_revert", 16'h0011, 16'(active));
      @(posedge clk);
      dly <= 16'h0000;
      closed <= 5'b01000;
      valid_mode <= 20'h00111;
      settle(12);
      chk("active", 16'h000F, 16'(active));
      s = st0;
      s.running = 1'b1;
      s.freq_zero = 1'b1;
      code_case(8'h00, s, 1'b0);
      code_case(8'h01, s, 1'b1);
      code_case(8'h05, s, 1'b1);
      s.running = 1'b0;
      code_case(8'h05, s, 1'b0);
      s = st0;
      s.fault_stop = 1'b1;
      code_case(8'h02, s, 1'b1);
      s.ready_to_run = 1'b1;
      code_case(8'h0F, s, 1'b0);
      s.fault_stop = 1'b0;
      code_case(8'h0F, s, 1'b1);
      code_case(8'h02, s, 1'b0);
      s = st0;
      s.motor_ovl_warn = 1'b1;
      code_case(8'h06, s, 1'b1);
      s = st0;
      s.drive_ovl_left = 16'h0064;
      code_case(8'h07, s, 1'b1);
      s.drive_ovl_left = 16'h0065;
      code_case(8'h07, s, 1'b0);
      s = st0;
      s.count_set_hit = 1'b1;
      code_case(8'h08, s, 1'b1);
      code_case(8'h09, s, 1'b0);
      s.count_des_hit = 1'b1;
      code_case(8'h09, s, 1'b1);
      s = st0;
      s.length_hit = 1'b1;
      code_case(8'h0A, s, 1'b1);
      s = st0;
      s.run_time_hit = 1'b1;
      code_case(8'h0C, s, 1'b1);
      s = st0;
      s.set_freq_beyond = 1'b1;
      code_case(8'h0D, s, 1'b0);
      s.out_freq_at_limit = 1'b1;
      code_case(8'h0D, s, 1'b1);
      s = st0;
      s.torque_stall = 1'b1;
      code_case(8'h0E, s, 1'b0);
      s.speed_mode = 1'b1;
      code_case(8'h0E, s, 1'b1);
      s = st0;
      s.freq_detect_one = 1'b1;
      code_case(8'h03, s, 1'b1);
      s.freq_reached = 1'b1;
      code_case(8'h04, s, 1'b1);
      // every flag but the sequencer event, so no pulse is left running
      s = '1;
      s.seq_cycle_done = 1'b0;
      code_case(8'h14, s, 1'b0);
      @(posedge clk);
      ain1 <= {16'h0300, 16'h0100, 16'h0000};
      ain2 <= {16'h0200, 16'h0100, 16'h0000};
      code_case(8'h10, st0, 1'b1);
      @(posedge clk);
      ain2 <= {16'h0300, 16'h0100, 16'h0000};
      code_case(8'h10, st0, 1'b0);
      s = st0;
      code_case(8'h0B, st0, 1'b0);
      s.seq_cycle_done = 1'b1;
      code_case(8'h0B, s, 1'b1);
      @(posedge clk);
      st_cmd <= st0;
      settle(2000);
      chk("pulse_held", 16'h0001, 16'(oc_out));
      // a reset in mid pulse must clear the pulse counter
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      settle(4);
      chk("pulse_cleared", 16'h0000, 16'(oc_out));
      final_report();
   end
endmodule
`default_nettype wire
